// ==== hw/adcbo_pkg.sv ====
// Shared constants, types and register map of the byte handshake output
package adcbo_pkg;
   localparam int DATA_W = 14;
   localparam int HI_W = 6;
   localparam int LO_W = 8;
   localparam int ADDR_W = 8;
   localparam int SYNC_W = 5;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'h08;
   // Control fields
   localparam int CTRL_HS_EN_BIT = 0;
   localparam int CTRL_DIRECT_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // Status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_MODE_BIT = 1;
   localparam int STAT_SEND_BIT = 2;
   localparam int STAT_PIN_BIT = 3;
   localparam int STAT_BYTE_BIT = 4;
   localparam logic [DATA_W-1:0] RESULT_RESET = 14'h0000;
   // Load strobe low time
   localparam int CLK_NS = 10;
   localparam int STROBE_NS = 50;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRB_CNT_W = 4;
   localparam logic [STRB_CNT_W-1:0] STROBE_LAST =
      STRB_CNT_W'(STROBE_CYC - 1);

   typedef enum logic [2:0] {
      HS_IDLE, HS_WAIT_READY, HS_STROBE, HS_WAIT_TAKEN, HS_WAIT_FREE, HS_END
   } adcbo_state_t;

   // Pin inputs from the far side, all asynchronous
   typedef struct packed {
      logic mode;
      logic send;
      logic ce_load_n;
      logic upper_byte_enable_n;
      logic lower_byte_enable_n;
   } adcbo_pins_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } adcbo_apb_rsp_t;
endpackage : adcbo_pkg

// ==== hw/adcbo_sync.sv ====
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module adcbo_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stage1 <= reset_val;
         sync_out <= reset_val;
      end else if (clk_en) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : adcbo_sync
`default_nettype wire

// ==== hw/adcbo_output.sv ====
// Byte-organised result output with direct and handshake modes
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module adcbo_output
   import adcbo_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcbo_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [adcbo_pkg::DATA_W-1:0] conv_result,
   input wire adcbo_pkg::adcbo_pins_t pins_in,
   output logic [adcbo_pkg::DATA_W-1:0] data_out,
   output logic [1:0] data_oe,
   output logic ce_load_out,
   output logic ce_load_oe,
   output logic upper_byte_enable_out,
   output logic upper_byte_enable_oe,
   output logic lower_byte_enable_out,
   output logic lower_byte_enable_oe,
   output logic status_out
);
   import adcbo_pkg::*;

   adcbo_pins_t pins;
   adcbo_state_t state;
   adcbo_state_t next_state;
   logic [1:0] ctrl;
   logic [DATA_W-1:0] result;
   logic mode_q;
   logic low_phase;
   logic next_low_phase;
   logic [STRB_CNT_W-1:0] strobe_cnt;
   adcbo_apb_rsp_t next_rsp;

   adcbo_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .async_in(pins_in),
      .reset_val({SYNC_W{1'b1}}),
      .sync_out(pins)
   );

   // Trigger decode
   wire hs_en = ctrl[CTRL_HS_EN_BIT];
   wire direct_en = ctrl[CTRL_DIRECT_EN_BIT];
   wire idle = (state == HS_IDLE);
   wire mode_rise = pins.mode && !mode_q;
   wire auto_trig = pins.mode && conv_done;
   wire start_seq = idle && hs_en && (mode_rise || auto_trig);
   wire strobe_end = (strobe_cnt == STROBE_LAST);

   // Result for the sequence in flight; a fresh one is taken only when idle
   wire take_result = conv_done && (idle || start_seq);

   // APB decode
   wire apb_setup = psel && !penable;
   wire apb_access = psel && penable && !pready;
   wire hit_ctrl = (paddr == CTRL_ADDR);
   wire hit_stat = (paddr == STAT_ADDR);
   wire hit_result = (paddr == RESULT_ADDR);
   wire hit_any = hit_ctrl || hit_stat || hit_result;
   // Write lands on the completing edge only
   wire ctrl_wr = psel && penable && pready && pwrite && hit_ctrl;
   wire [31:0] stat_word = {27'h0000000, low_phase, status_out,
                            pins.send, pins.mode, !idle};
   wire [31:0] read_word = hit_ctrl ? {30'h00000000, ctrl} :
                           hit_stat ? stat_word :
                           hit_result ? {18'h00000, result} : 32'h00000000;

   always_comb begin
      next_rsp.ready = apb_access;
      next_rsp.slverr = apb_access && !hit_any;
      next_rsp.rdata = (apb_access && !pwrite) ? read_word : 32'h00000000;
   end

   // Handshake sequencer
   always_comb begin
      next_state = state;
      next_low_phase = low_phase;
      case (state)
         HS_IDLE: begin
            next_low_phase = 1'b0;
            if (start_seq) begin
               next_state = HS_WAIT_READY;
            end
         end
         HS_WAIT_READY: begin
            if (pins.send) begin
               next_state = HS_STROBE;
            end
         end
         HS_STROBE: begin
            if (strobe_end) begin
               next_state = HS_WAIT_TAKEN;
            end
         end
         HS_WAIT_TAKEN: begin
            if (!pins.send) begin
               next_state = HS_WAIT_FREE;
            end
         end
         HS_WAIT_FREE: begin
            if (pins.send) begin
               if (low_phase) begin
                  next_state = HS_END;
               end else begin
                  next_low_phase = 1'b1;
                  next_state = HS_STROBE;
               end
            end
         end
         HS_END: begin
            next_state = HS_IDLE;
         end
         default: begin
            next_state = HS_IDLE;
         end
      endcase
   end

   // Decode from next state so lines and byte flags move together
   wire next_in_seq = (next_state != HS_IDLE) && (next_state != HS_END);
   wire next_idle = (next_state == HS_IDLE);
   wire drive_hi_direct = direct_en && next_idle && !pins.ce_load_n &&
                          !pins.upper_byte_enable_n;
   wire drive_lo_direct = direct_en && next_idle && !pins.ce_load_n &&
                          !pins.lower_byte_enable_n;
   wire drive_hi_hs = next_in_seq && !next_low_phase;
   wire drive_lo_hs = next_in_seq && next_low_phase;
   wire [1:0] next_oe = {drive_hi_direct || drive_hi_hs,
                         drive_lo_direct || drive_lo_hs};
   wire next_strobe_n = !(next_state == HS_STROBE);
   wire next_ube = !(next_state != HS_IDLE && next_state != HS_END &&
                     !next_low_phase);
   wire next_lbe = !(next_state != HS_IDLE && next_state != HS_END &&
                     next_low_phase);
   wire next_flag_oe = (next_state != HS_IDLE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= HS_IDLE;
         low_phase <= 1'b0;
         strobe_cnt <= '0;
         mode_q <= 1'b1;
      end else if (clk_en) begin
         state <= next_state;
         low_phase <= next_low_phase;
         mode_q <= pins.mode;
         strobe_cnt <= (state == HS_STROBE && !strobe_end) ?
                       strobe_cnt + 1'b1 : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl <= CTRL_RESET;
         result <= RESULT_RESET;
         status_out <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         if (ctrl_wr) begin
            ctrl <= pwdata[1:0];
         end
         if (take_result) begin
            result <= conv_result;
         end
         if (conv_done) begin
            status_out <= 1'b0;
         end else if (conv_start) begin
            status_out <= 1'b1;
         end
         pready <= next_rsp.ready;
         pslverr <= next_rsp.slverr;
         prdata <= next_rsp.rdata;
      end
   end

   // Pin drivers; data lines carry the latched result at all times
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_out <= RESULT_RESET;
         data_oe <= 2'h0;
         ce_load_out <= 1'b1;
         ce_load_oe <= 1'b0;
         upper_byte_enable_out <= 1'b1;
         upper_byte_enable_oe <= 1'b0;
         lower_byte_enable_out <= 1'b1;
         lower_byte_enable_oe <= 1'b0;
      end else if (clk_en) begin
         data_out <= take_result ? conv_result : result;
         data_oe <= next_oe;
         ce_load_out <= next_strobe_n;
         ce_load_oe <= next_flag_oe;
         upper_byte_enable_out <= next_ube;
         upper_byte_enable_oe <= next_flag_oe;
         lower_byte_enable_out <= next_lbe;
         lower_byte_enable_oe <= next_flag_oe;
      end
   end

   logic unused_apb;
   assign unused_apb = apb_setup ^ (^pwdata[31:2]);
endmodule : adcbo_output
`default_nettype wire

// ==== verification/adcbo_output_props.sv ====
// Checker of the result output pins
`timescale 1ns/1ns
`default_nettype none
module adcbo_output_props
   import adcbo_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire adcbo_pkg::adcbo_pins_t pins_in,
   input wire logic conv_done,
   input wire logic [1:0] data_oe,
   input wire logic ce_load_out,
   input wire logic ce_load_oe,
   input wire logic upper_byte_enable_out,
   input wire logic upper_byte_enable_oe,
   input wire logic lower_byte_enable_oe,
   input wire logic lower_byte_enable_out,
   input wire logic status_out
);
   import adcbo_pkg::*;
   wire logic hi_sel = !pins_in.ce_load_n && !pins_in.upper_byte_enable_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_strobe_width: assert property (
      $fell(ce_load_out) && ce_load_oe |=> !ce_load_out [*4] ##1 ce_load_out)
      else $error("load strobe width wrong");
   a_strobe_drives: assert property (
      !ce_load_out && ce_load_oe |-> ^data_oe)
      else $error("no single byte driven during strobe");
   a_flag_byte: assert property (
      ce_load_oe && data_oe[1] |-> upper_byte_enable_oe
      && !upper_byte_enable_out)
      else $error("upper flag not marking upper byte");
   a_hi_first: assert property (
      $rose(upper_byte_enable_oe) |-> data_oe == 2'b10)
      else $error("sequence did not open with upper byte");
   a_lo_after_hi: assert property (
      $fell(data_oe[1]) && ce_load_oe |-> data_oe == 2'b01)
      else $error("lower byte did not follow upper byte");
   a_end_flag: assert property (
      $fell(lower_byte_enable_oe) |-> $past(lower_byte_enable_out))
      else $error("lower flag not high at sequence end");
   a_lines_free: assert property (
      $fell(lower_byte_enable_oe) |-> data_oe == 2'b00 && !ce_load_oe)
      else $error("lines not released after sequence");
   a_direct_sel: assert property (
      !ce_load_oe && data_oe[1] |-> $past(hi_sel, 3))
      else $error("upper byte driven without selection");
   a_status_fall: assert property (
      conv_done |=> !status_out)
      else $error("status did not fall on new data");
endmodule : adcbo_output_props
bind adcbo_output adcbo_output_props u_props (.clk, .resetn, .pins_in,
   .conv_done, .data_oe, .ce_load_out, .ce_load_oe, .upper_byte_enable_out,
   .upper_byte_enable_oe, .lower_byte_enable_oe, .lower_byte_enable_out,
   .status_out);
`default_nettype wire

// ==== verification/adcbo_rx_model.sv ====
// Byte receiver model on the handshake side
`timescale 1ns/1ns
`default_nettype none
module adcbo_rx_model
   import adcbo_pkg::*;
(
   input wire logic clk,
   input wire logic ce_load,
   input wire logic load_oe,
   input wire logic [adcbo_pkg::DATA_W-1:0] data_out,
   input wire logic [1:0] data_oe,
   input wire logic [3:0] hold_cyc,
   output logic send,
   output logic [15:0] pair,
   output logic [3:0] byte_cnt
);
   import adcbo_pkg::*;
   logic prev_load = 1'b1;
   logic [3:0] busy = 4'h0;
   initial begin
      pair = 16'h0000;
      byte_cnt = 4'h0;
   end
   assign send = (busy == 4'h0);
   always @(posedge clk) begin
      prev_load <= ce_load;
      if (load_oe && ce_load && !prev_load) begin
         busy <= hold_cyc;
         byte_cnt <= byte_cnt + 4'h1;
         pair <= {pair[7:0], data_oe[1] ? {2'h0, data_out[13:8]}
            : data_out[7:0]};
      end else if (busy != 4'h0) begin
         busy <= busy - 4'h1;
      end
   end
endmodule : adcbo_rx_model
`default_nettype wire

// ==== verification/adcbo_output_test.sv ====
// Self-checking bench of the result output
`timescale 1ns/1ns
`default_nettype none
module adcbo_output_test;
   import adcbo_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic conv_start = 1'b0;
   logic conv_done = 1'b0;
   logic [DATA_W-1:0] conv_result = 14'h0;
   logic mode = 1'b0;
   logic ce_n = 1'b1;
   logic up_n = 1'b1;
   logic lo_n = 1'b1;
   logic [3:0] hold_cyc = 4'h3;
   logic [31:0] prdata;
   logic pready, pslverr, ce_load_out, ce_load_oe, status_out, send;
   logic up_out, up_oe, lo_out, lo_oe;
   logic [DATA_W-1:0] data_out;
   logic [1:0] data_oe;
   logic [15:0] pair;
   logic [3:0] byte_cnt;
   int error_cnt = 0;
   int cmp_count = 0;
   wire logic ce_w = ce_load_oe ? ce_load_out : ce_n;
   adcbo_pins_t pins;
   assign pins = {mode, send, ce_w, up_oe ? up_out : up_n,
      lo_oe ? lo_out : lo_n};
   always #5 clk = ~clk;
   adcbo_output dut (.clk, .resetn, .clk_en(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start,
      .conv_done, .conv_result, .pins_in(pins), .data_out, .data_oe,
      .ce_load_out, .ce_load_oe, .upper_byte_enable_out(up_out),
      .upper_byte_enable_oe(up_oe), .lower_byte_enable_out(lo_out),
      .lower_byte_enable_oe(lo_oe), .status_out);
   adcbo_rx_model rx (.clk, .ce_load(ce_w), .load_oe(ce_load_oe),
      .data_out, .data_oe, .hold_cyc, .send, .pair, .byte_cnt);
   task automatic chk(input logic [31:0] e, input logic [31:0] g,
      input string what);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never reassigns psel at once
      @(posedge clk);
   endtask : apb
   task automatic conv(input logic [13:0] v);
      conv_result <= v;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask : conv
   task automatic pins_chk(input logic c, input logic u, input logic l,
      input logic [1:0] oe);
      ce_n <= c;
      up_n <= u;
      lo_n <= l;
      repeat (4) @(posedge clk);
      chk(32'(oe), 32'(data_oe), "direct oe");
   endtask : pins_chk
   task automatic seq(input logic [13:0] v, input logic [3:0] c);
      int n;
      n = 0;
      while ((byte_cnt !== c + 4'h2 || lo_oe !== 1'b0) && n < 900) begin
         @(posedge clk);
         n++;
      end
      chk(32'(c + 4'h2), 32'(byte_cnt), "byte count");
      chk(32'(v), 32'(pair), "byte pair");
      chk(32'h0, 32'(data_oe), "lines free");
   endtask : seq
   task automatic t_regs_direct;
      logic [31:0] r;
      logic e;
      apb(1'b0, CTRL_ADDR, 32'h0, r, e);
      chk(32'h3, r, "ctrl reset");
      apb(1'b0, 8'h0C, 32'h0, r, e);
      chk(32'h1, 32'(e), "unmapped err");
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      conv(14'h2A5C);
      @(posedge clk);
      chk(32'h0, 32'(status_out), "status");
      apb(1'b0, STAT_ADDR, 32'h0, r, e);
      chk(32'h1 << STAT_SEND_BIT, r, "stat word");
      apb(1'b0, RESULT_ADDR, 32'h0, r, e);
      chk(32'h2A5C, r, "result");
      pins_chk(1'b0, 1'b0, 1'b1, 2'b10);
      chk(32'h2A, 32'(data_out[13:8]), "upper byte");
      pins_chk(1'b0, 1'b1, 1'b0, 2'b01);
      chk(32'h5C, 32'(data_out[7:0]), "lower byte");
      apb(1'b1, CTRL_ADDR, 32'h1, r, e);
      pins_chk(1'b0, 1'b0, 1'b0, 2'b00);
      apb(1'b1, CTRL_ADDR, 32'h3, r, e);
      pins_chk(1'b1, 1'b1, 1'b1, 2'b00);
   endtask : t_regs_direct
   task automatic t_hs;
      logic [31:0] r;
      logic e;
      logic [3:0] c0;
      mode <= 1'b1;
      seq(14'h2A5C, byte_cnt);
      hold_cyc <= 4'hC;
      c0 = byte_cnt;
      conv(14'h1381);
      repeat (20) @(posedge clk);
      conv(14'h0F0F);
      seq(14'h1381, c0);
      apb(1'b0, RESULT_ADDR, 32'h0, r, e);
      chk(32'h1381, r, "held result");
      mode <= 1'b0;
   endtask : t_hs
   task automatic give_verdict;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs_direct();
      t_hs();
      give_verdict();
   end
endmodule : adcbo_output_test
`default_nettype wire
